// ---- ssi_defs.svh ----
// Register offsets, field positions and reset values for the interlock
`ifndef SSI_DEFS_SVH
`define SSI_DEFS_SVH
// ****************************************
// Register byte addresses
// ****************************************
`define SSI_CTRL_ADDR 4'h0
`define SSI_STAT_ADDR 4'h4
`define SSI_IRQ_ADDR 4'h8
`define SSI_MASK_ADDR 4'hC
// ****************************************
// Control fields
// ****************************************
`define SSI_CTRL_OPER 0
`define SSI_CTRL_LOWEN 1
`define SSI_CTRL_RANGE_LO 2
`define SSI_CTRL_RESET 32'h0000_0000
// ****************************************
// Status fields
// ****************************************
`define SSI_STAT_FAIL 0
`define SSI_STAT_OUTON 1
`define SSI_STAT_HIZ 2
// ****************************************
// Event bits
// ****************************************
`define SSI_EV_REFUSED 0
`define SSI_EV_TRIP 1
`define SSI_EV_ASSERT 2
`define SSI_EV_W 3
`define SSI_MASK_RESET 3'h0
`endif

// ---- ssi_pkg.sv ----
// Types shared by the interlock design
package ssi_pkg;
   // Output voltage range selection
   typedef enum logic [1:0] {
      SSI_RANGE_10V = 2'h0,
      SSI_RANGE_50V = 2'h1,
      SSI_RANGE_500V = 2'h2,
      SSI_RANGE_RSVD = 2'h3
   } ssi_range_t;
endpackage

// ---- ssi_sync.sv ----
// Three-flop synchroniser with agreement filter for the lid switch input
module ssi_sync (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Raw and filtered levels
   input wire logic din,
   output logic dout
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic q;
   } ssi_sync_t;
   ssi_sync_t r, next_r;
   // ****************************************
   // Sampling chain
   // ****************************************
   // Second and third stage agreement updates the output
   always_comb begin
      next_r = r;
      next_r.s1 = din;
      next_r.s2 = r.s1;
      next_r.s3 = r.s2;
      if (r.s2 == r.s3) begin
         next_r.q = r.s2;
      end
   end
   // Reset shows the switch open, which is the safe side
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         r <= 4'hF;
      end else begin
         r <= next_r;
      end
   end
   assign dout = r.q;
endmodule

// ---- ssi_interlock.sv ----
// Voltage source safety interlock with Avalon-MM register slave
//
// Implementation choices: the placing of the registers and the Avalon-MM register port.
`include "ssi_defs.svh"
module ssi_interlock import ssi_pkg::*; (
   // Clock and reset
   input wire logic CLK,
   input wire logic RESET_N,
   // Lid switch: high when contacts open or floating
   input wire logic LOCK_OPEN,
   // Avalon-MM slave
   input wire logic [3:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   // Source control
   output logic SRC_OPERATE,
   output logic SRC_HIZ,
   output logic [1:0] SRC_RANGE,
   // Interrupt
   output logic IRQ
);
   typedef struct packed {
      logic oper;
      logic low_en;
      ssi_range_t range;
      logic [`SSI_EV_W-1:0] irq_stat;
      logic [`SSI_EV_W-1:0] irq_mask;
      logic [31:0] rdata;
      logic ack;
      logic lock_d;
   } ssi_state_t;
   ssi_state_t r, next_r;
   logic lock;
   logic gated;
   logic blocked;
   logic [31:0] status_word;
   logic [`SSI_EV_W-1:0] ev;
   logic req;
   // ****************************************
   // Input synchronisation
   // ****************************************
   // Lid level into the clock domain
   ssi_sync u_sync (
      .clk(CLK),
      .reset_n(RESET_N),
      .din(LOCK_OPEN),
      .dout(lock)
   );
   // ****************************************
   // Gating decision
   // ****************************************
   // Range-dependent gating and refusal
   always_comb begin
      gated = (r.range != SSI_RANGE_10V) || r.low_en;
      blocked = lock && gated;
   end
   // Status word, fail bit independent of range
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[`SSI_STAT_FAIL] = lock;
      status_word[`SSI_STAT_OUTON] = r.oper;
      status_word[`SSI_STAT_HIZ] = ~r.oper;
   end
   // ****************************************
   // Register and control logic
   // ****************************************
   assign req = (AVS_READ || AVS_WRITE) && !r.ack;
   always_comb begin
      next_r = r;
      ev = '0;
      next_r.ack = req;
      next_r.lock_d = lock;
      if (lock && !r.lock_d) begin
         ev[`SSI_EV_ASSERT] = 1'b1;
      end
      if (req && AVS_WRITE) begin
         unique case (AVS_ADDRESS)
            `SSI_CTRL_ADDR: begin
               next_r.low_en = AVS_WRITEDATA[`SSI_CTRL_LOWEN];
               if (AVS_WRITEDATA[`SSI_CTRL_RANGE_LO+1 -: 2] != 2'h3) begin
                  next_r.range = ssi_range_t'(AVS_WRITEDATA[`SSI_CTRL_RANGE_LO+1 -: 2]);
               end
               next_r.oper = AVS_WRITEDATA[`SSI_CTRL_OPER];
            end
            `SSI_IRQ_ADDR: begin
               next_r.irq_stat = r.irq_stat & ~AVS_WRITEDATA[`SSI_EV_W-1:0];
            end
            `SSI_MASK_ADDR: begin
               next_r.irq_mask = AVS_WRITEDATA[`SSI_EV_W-1:0];
            end
            default: begin
            end
         endcase
      end
      // Operate request refused while the new setting would be gated
      if (next_r.oper && lock && ((next_r.range != SSI_RANGE_10V) || next_r.low_en)) begin
         if (!r.oper) begin
            ev[`SSI_EV_REFUSED] = 1'b1;
         end else begin
            ev[`SSI_EV_TRIP] = 1'b1;
         end
         next_r.oper = 1'b0;
      end
      // A running source on a gated range drops out even when a write lands
      if (r.oper && lock && gated) begin
         ev[`SSI_EV_TRIP] = 1'b1;
         next_r.oper = 1'b0;
      end
      // Events win over a clear in the same cycle
      next_r.irq_stat = next_r.irq_stat | ev;
      if (req && AVS_READ) begin
         unique case (AVS_ADDRESS)
            `SSI_CTRL_ADDR: begin
               next_r.rdata = {28'h000_0000, r.range, r.low_en, r.oper};
            end
            `SSI_STAT_ADDR: begin
               next_r.rdata = status_word;
            end
            `SSI_IRQ_ADDR: begin
               next_r.rdata = {29'h0000_0000, r.irq_stat};
            end
            `SSI_MASK_ADDR: begin
               next_r.rdata = {29'h0000_0000, r.irq_mask};
            end
            default: begin
               next_r.rdata = 32'h0000_0000;
            end
         endcase
      end
   end
   // State register
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         r.oper <= 1'b0;
         r.low_en <= 1'b0;
         r.range <= SSI_RANGE_10V;
         r.irq_stat <= '0;
         r.irq_mask <= `SSI_MASK_RESET;
         r.rdata <= 32'h0000_0000;
         r.ack <= 1'b0;
         r.lock_d <= 1'b1;
      end else begin
         r <= next_r;
      end
   end
   // ****************************************
   // Outputs
   // ****************************************
   assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !r.ack;
   assign AVS_READDATA = r.rdata;
   assign SRC_OPERATE = r.oper;
   assign SRC_HIZ = ~r.oper;
   assign SRC_RANGE = r.range;
   assign IRQ = |(r.irq_stat & r.irq_mask);
   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   // Gating and reserved range checks
   never_gated_on_a: assert property ($rose(r.oper) |-> !($past(lock) && gated))
      else $error("source entered operate while gated and asserted");
   trip_hiz_a: assert property ((r.oper && lock && gated) |=> SRC_HIZ)
      else $error("trip did not force high impedance");
   high_range_gate_a: assert property ((req && AVS_WRITE && AVS_ADDRESS == `SSI_CTRL_ADDR
      && lock && (AVS_WRITEDATA[`SSI_CTRL_RANGE_LO+1 -: 2] == 2'h1
      || AVS_WRITEDATA[`SSI_CTRL_RANGE_LO+1 -: 2] == 2'h2)) |=> !r.oper)
      else $error("high range operate not refused");
   low_range_gate_a: assert property ((req && AVS_WRITE && AVS_ADDRESS == `SSI_CTRL_ADDR
      && AVS_WRITEDATA[`SSI_CTRL_RANGE_LO+1 -: 2] == 2'h0 && !AVS_WRITEDATA[`SSI_CTRL_LOWEN]
      && AVS_WRITEDATA[`SSI_CTRL_OPER] && !r.oper) |=> r.oper)
      else $error("10V operate refused without enable");
   range_keep_a: assert property ((req && AVS_WRITE && AVS_ADDRESS == `SSI_CTRL_ADDR
      && AVS_WRITEDATA[`SSI_CTRL_RANGE_LO+1 -: 2] == 2'h3) |=> r.range == $past(r.range))
      else $error("reserved range code changed the range");
   // Status, synchroniser and refusal checks
   fail_reads_a: assert property ((req && AVS_READ && AVS_ADDRESS == `SSI_STAT_ADDR)
      |=> AVS_READDATA[`SSI_STAT_FAIL] == $past(lock))
      else $error("fail bit does not reflect interlock");
   sync_follow_a: assert property ($rose(lock) |-> $past(u_sync.r.s3) && $past(u_sync.r.s2))
      else $error("lock changed without agreement");
   refuse_event_a: assert property ((req && AVS_WRITE && AVS_ADDRESS == `SSI_CTRL_ADDR
      && AVS_WRITEDATA[`SSI_CTRL_OPER] && lock && !r.oper
      && AVS_WRITEDATA[`SSI_CTRL_RANGE_LO+1 -: 2] == 2'h1)
      |=> !r.oper && r.irq_stat[`SSI_EV_REFUSED])
      else $error("operate request not refused");
   // Bus timing and interrupt checks
   wait_one_a: assert property ((AVS_READ || AVS_WRITE) && !r.ack |=> !AVS_WAITREQUEST)
      else $error("waitrequest held too long");
   irq_level_a: assert property ((IRQ && !(req && AVS_WRITE)) |=> IRQ)
      else $error("interrupt dropped without a write");
   lock_event_a: assert property ($rose(lock) |=> r.irq_stat[`SSI_EV_ASSERT])
      else $error("interlock rise not latched");
   // Scenario coverage
   trip_c: cover property (r.oper && lock && gated ##1 SRC_HIZ);
   range_hold_c: cover property (req && AVS_WRITE && AVS_WRITEDATA[`SSI_CTRL_RANGE_LO+1 -: 2] == 2'h3);
   refuse_c: cover property (ev[`SSI_EV_REFUSED]);
   low_on_c: cover property (r.oper && r.range == SSI_RANGE_10V && lock);
   irq_c: cover property ($rose(IRQ));
endmodule

// ---- ssi_lid_model.sv ----
// Lid switch model standing across the interlock contacts
module ssi_lid_model (
   // Lid position from the bench
   input wire logic lid_shut,
   // Contact level seen by the instrument
   output logic lock_open
);
   timeunit 1ns;
   timeprecision 1ps;
   // Contacts shorted only while the lid is shut
   assign lock_open = !lid_shut;
endmodule

// ---- tb.sv ----
// Self-checking bench for the source interlock
`include "ssi_defs.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic CLK = 1'b0;
   logic RESET_N = 1'b0;
   logic lid_shut = 1'b0;
   logic LOCK_OPEN;
   logic [3:0] AVS_ADDRESS = 4'h0;
   logic AVS_READ = 1'b0;
   logic AVS_WRITE = 1'b0;
   logic [31:0] AVS_WRITEDATA = 32'h0000_0000;
   logic [31:0] AVS_READDATA;
   logic AVS_WAITREQUEST;
   logic SRC_OPERATE;
   logic SRC_HIZ;
   logic [1:0] SRC_RANGE;
   logic IRQ;
   logic [31:0] rdat;
   int error_cnt = 0;
   int check_count = 0;
   always #2 CLK = ~CLK;
   ssi_lid_model i_lid (.lid_shut(lid_shut), .lock_open(LOCK_OPEN));
   ssi_interlock i_dut (.CLK(CLK), .RESET_N(RESET_N), .LOCK_OPEN(LOCK_OPEN),
      .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
      .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
      .AVS_WAITREQUEST(AVS_WAITREQUEST), .SRC_OPERATE(SRC_OPERATE),
      .SRC_HIZ(SRC_HIZ), .SRC_RANGE(SRC_RANGE), .IRQ(IRQ));
   // ****************************************
   // Bus and compare tasks
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One Avalon access, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] dat);
      int n;
      n = 0;
      @(posedge CLK);
      AVS_ADDRESS <= adr;
      AVS_WRITEDATA <= dat;
      AVS_WRITE <= wr;
      AVS_READ <= !wr;
      do begin
         @(posedge CLK);
         n++;
      end while (AVS_WAITREQUEST !== 1'b0 && n < 50);
      rdat = AVS_READDATA;
      AVS_WRITE <= 1'b0;
      AVS_READ <= 1'b0;
      chk(32'(n < 50), 32'h0000_0001);
   endtask
   task automatic rdck(input logic [3:0] adr, input logic [31:0] exp);
      bus(1'b0, adr, 32'h0000_0000);
      chk(rdat, exp);
   endtask
   // Request operate on a range, check the outcome, then stand down
   task automatic op(input logic [1:0] rng, input logic lowen, input logic e);
      bus(1'b1, `SSI_CTRL_ADDR, {28'h000_0000, rng, lowen, 1'b1});
      chk({SRC_OPERATE, SRC_HIZ}, {e, !e});
      chk(SRC_RANGE, rng);
      bus(1'b1, `SSI_CTRL_ADDR, {28'h000_0000, rng, lowen, 1'b0});
   endtask
   task automatic lid(input logic v);
      lid_shut <= v;
      repeat (8) @(posedge CLK);
   endtask
   task automatic complete_run();
      if (error_cnt == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      repeat (2) @(posedge CLK);
      RESET_N <= 1'b1;
      // Reset values and unmapped address
      rdck(`SSI_CTRL_ADDR, 32'h0000_0000);
      rdck(`SSI_MASK_ADDR, 32'h0000_0000);
      rdck(4'h2, 32'h0000_0000);
      lid(1'b1);
      rdck(`SSI_STAT_ADDR, 32'h0000_0004);
      // Lid shut: every range may operate
      op(2'h0, 1'b1, 1'b1);
      op(2'h1, 1'b0, 1'b1);
      op(2'h2, 1'b0, 1'b1);
      // Lid open: fail flag on every range
      lid(1'b0);
      bus(1'b1, `SSI_IRQ_ADDR, 32'h0000_0007);
      for (int r = 0; r < 3; r++) begin
         bus(1'b1, `SSI_CTRL_ADDR, 32'(r << 2));
         rdck(`SSI_STAT_ADDR, 32'h0000_0005);
      end
      // Reserved range code keeps the range
      bus(1'b1, `SSI_CTRL_ADDR, 32'h0000_000C);
      chk(SRC_RANGE, 2'h2);
      op(2'h1, 1'b0, 1'b0);
      op(2'h2, 1'b0, 1'b0);
      op(2'h0, 1'b0, 1'b1);
      op(2'h0, 1'b1, 1'b0);
      rdck(`SSI_IRQ_ADDR, 32'h0000_0001);
      // Trip while operating, then mask and clear
      bus(1'b1, `SSI_IRQ_ADDR, 32'h0000_0007);
      bus(1'b1, `SSI_MASK_ADDR, 32'h0000_0002);
      lid(1'b1);
      bus(1'b1, `SSI_CTRL_ADDR, 32'h0000_0009);
      chk(SRC_OPERATE, 1'b1);
      rdck(`SSI_STAT_ADDR, 32'h0000_0002);
      lid(1'b0);
      chk({SRC_OPERATE, SRC_HIZ, IRQ}, 3'h3);
      rdck(`SSI_IRQ_ADDR, 32'h0000_0006);
      bus(1'b1, `SSI_IRQ_ADDR, 32'h0000_0002);
      chk(IRQ, 1'b0);
      bus(1'b1, `SSI_MASK_ADDR, 32'h0000_0004);
      chk(IRQ, 1'b1);
      bus(1'b1, `SSI_IRQ_ADDR, 32'h0000_0004);
      chk(IRQ, 1'b0);
      // Reset in mid-run returns the low-range enable to off
      bus(1'b1, `SSI_CTRL_ADDR, 32'h0000_0002);
      rdck(`SSI_CTRL_ADDR, 32'h0000_0002);
      RESET_N <= 1'b0;
      repeat (2) @(posedge CLK);
      RESET_N <= 1'b1;
      chk({SRC_OPERATE, SRC_HIZ, IRQ}, 3'h2);
      rdck(`SSI_CTRL_ADDR, 32'h0000_0000);
      rdck(`SSI_IRQ_ADDR, 32'h0000_0000);
      rdck(`SSI_MASK_ADDR, 32'h0000_0000);
      complete_run();
   end
   // Watchdog for a hung access
   initial begin
      repeat (5000) @(posedge CLK);
      error_cnt++;
      complete_run();
   end
endmodule
